// ### core/smsp_fifo.sv
// Byte FIFO between the serial link and the command parser.
`timescale 1ns/1ns
`default_nettype none
module smsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             ref_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   logic [AW:0]      next_wr_ptr;
   logic [AW:0]      next_rd_ptr;
   logic             wr_en;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("FIFO depth must be a power of two of at least 2.");
   end

   assign in_ready_o  = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_valid_o = wr_ptr != rd_ptr;
   assign out_data_o  = mem[rd_ptr[AW-1:0]];
   assign wr_en       = in_valid_i && in_ready_o;

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      if (wr_en) begin
         next_wr_ptr = wr_ptr + 1'b1;
      end
      if (out_valid_o && out_ready_i) begin
         next_rd_ptr = rd_ptr + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
      if (wr_en) begin
         mem[wr_ptr[AW-1:0]] <= in_data_i;
      end
   end
endmodule
`default_nettype wire

// ### core/smsp_pkg.sv
// Constants, types and timing counts of the serial slave port.
package smsp_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int RESET_MIN_NS  = 2000;
   localparam int RESET_MIN_CYC =
      (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INIT_TEST_NS  = 20000;
   localparam int INIT_TEST_CYC =
      (INIT_TEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DEF_TEST_NS   = 400000;
   localparam int DEF_TEST_CYC  =
      (DEF_TEST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BG_IDLE_NS    = 40000;
   localparam int BG_IDLE_CYC   =
      (BG_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   localparam logic [15:0] OFF_STS  = 16'h0018;
   localparam logic [15:0] OFF_DATA = 16'h0024;
   localparam logic [15:0] OFF_ID   = 16'h0f00;
   localparam logic [15:0] OFF_RID  = 16'h0f04;
   localparam int STS_INIT_DONE = 0;
   localparam int STS_DEF_DONE  = 1;
   localparam int STS_OVERFLOW  = 2;
   localparam int STS_AVAIL     = 4;
   localparam int STS_CMD_READY = 6;
   localparam int HDR_READ_BIT  = 7;

   localparam logic [7:0] WAIT_BYTE     = 8'h00;
   localparam logic [7:0] READY_BYTE    = 8'h01;
   localparam logic [7:0] UNMAPPED_BYTE = 8'hff;
   localparam logic [31:0] CODE_FULL_TEST = 32'h0000_0001;
   localparam logic [31:0] CODE_INCR_TEST = 32'h0000_0002;
   localparam logic [31:0] CODE_RANDOM    = 32'h0000_0003;
   localparam logic [31:0] CODE_HASH      = 32'h0000_0004;
   localparam logic [31:0] RC_SUCCESS     = 32'h0000_0000;
   localparam logic [31:0] RC_TESTING     = 32'h0000_0001;
   localparam logic [15:0] CMD_HDR_LAST   = 16'h0009;
   localparam logic [3:0]  RESP_LEN       = 4'ha;
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 8;

   typedef struct packed {
      logic clk;
      logic cs_n;
      logic mosi;
   } smsp_pins_t;
   localparam smsp_pins_t PINS_IDLE = '{clk: 1'b1, cs_n: 1'b1, mosi: 1'b0};

   typedef struct packed {
      logic        read;
      logic [5:0]  len_m1;
      logic [15:0] addr;
   } smsp_hdr_t;

   typedef struct packed {
      logic [15:0] tag;
      logic [31:0] size;
      logic [31:0] code;
   } smsp_resp_t;

   typedef enum logic [3:0] {
      LK_IDLE = 4'b0001, LK_HDR = 4'b0010,
      LK_WAIT = 4'b0100, LK_DATA = 4'b1000
   } smsp_link_t;

   typedef enum logic [3:0] {
      DT_IDLE = 4'b0001, DT_CMD = 4'b0010,
      DT_BG = 4'b0100, DT_DONE = 4'b1000
   } smsp_dtest_t;
endpackage

// ### core/smsp_spi_slave.sv
// Serial slave port of the security module with self-test sequencing.
`timescale 1ns/1ns
`default_nettype none
module smsp_spi_slave #(
   // Identity values are arbitrary.
   parameter logic [15:0] DEVICE_ID       = 16'h5a01,
   parameter logic [15:0] VENDOR_ID       = 16'h00aa,
   parameter logic [7:0]  REVISION        = 8'h11,
   parameter int          DEF_TEST_CYCLES = smsp_pkg::DEF_TEST_CYC,
   parameter int          FIFO_DEPTH      = smsp_pkg::FIFO_DEPTH
) (
   input  wire logic ref_clk_i,
   input  wire logic reset_n_i,
   input  wire logic spi_clk_i,
   input  wire logic spi_cs_n_i,
   input  wire logic mosi_i,
   output logic      miso_o,
   output logic      interrupt_request_n_o,
   output logic      interrupt_request_n_oe_n_o
);
   import smsp_pkg::*;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   if (DEF_TEST_CYCLES < 1 || DEF_TEST_CYCLES >= (1 << 24)) begin : g_chk
      $error("Deferred test length out of range.");
   end

   smsp_pins_t  pins_in, pins_s1, pins_s2, pins_d;
   logic        clk_rise, clk_fall;
   smsp_link_t  state, next_state;
   logic [2:0]  bit_cnt, next_bit_cnt;
   logic [7:0]  shift_in, next_shift_in;
   logic [7:0]  tx_shift, next_tx_shift;
   logic        miso_bit, next_miso;
   logic [1:0]  hdr_cnt, next_hdr_cnt;
   smsp_hdr_t   hdr, next_hdr;
   logic        sent_ready, next_sent_ready;
   logic [6:0]  rx_cnt, next_rx_cnt;
   logic [6:0]  tx_cnt, next_tx_cnt;
   logic [7:0]  rx_byte, tx_byte, read_byte;
   logic        byte_done, load, push, pop_resp, clear_cmd;
   logic        dev_ready;
   logic        fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [7:0]  fifo_data;
   logic [15:0] cmd_cnt, next_cmd_cnt;
   logic [15:0] tag, next_tag;
   logic [31:0] size, next_size;
   logic [31:0] code, next_code;
   smsp_resp_t  resp, next_resp;
   logic        resp_valid, next_resp_valid;
   logic [3:0]  rd_ptr, next_rd_ptr;
   logic        overflow, next_overflow;
   logic        irq_oe_n, next_irq_oe_n;
   logic        data_avail, exec, start_test, self_cmd, untested;
   logic [15:0] init_cnt, next_init_cnt;
   logic        init_done, next_init_done;
   smsp_dtest_t dt, next_dt;
   logic [23:0] def_cnt, next_def_cnt;
   logic [15:0] idle_cnt, next_idle_cnt;
   logic        def_done;
   logic [31:0] sts_word, id_word, rid_word;
   logic [15:0] since_rst;

   function automatic logic [7:0] word_byte(input logic [31:0] w,
                                            input logic [1:0]  i);
      return w[{i, 3'b000} +: 8];
   endfunction

   function automatic logic [7:0] resp_byte(input smsp_resp_t r,
                                            input logic [3:0] i);
      logic [79:0] v;
      v = r;
      return v[7'd79 - {i, 3'b000} -: 8];
   endfunction

   // The serial clock is only sampled; this port never drives it.
   assign pins_in  = '{clk: spi_clk_i, cs_n: spi_cs_n_i, mosi: mosi_i};
   assign clk_rise = pins_s2.clk && !pins_d.clk;
   assign clk_fall = !pins_s2.clk && pins_d.clk;

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         pins_s1 <= PINS_IDLE;
         pins_s2 <= PINS_IDLE;
         pins_d  <= PINS_IDLE;
      end else begin
         pins_s1 <= pins_in;
         pins_s2 <= pins_s1;
         pins_d  <= pins_s2;
      end
   end

   assign sts_word = {25'h0, 1'b0, 1'b0, data_avail, 1'b0, overflow,
                      def_done, init_done};
   assign id_word  = {DEVICE_ID, VENDOR_ID};
   assign rid_word = {24'h0, REVISION};
   assign data_avail = resp_valid && (rd_ptr < RESP_LEN);
   assign dev_ready  = init_done && (hdr.read || hdr.addr != OFF_DATA ||
                       (!fifo_out_valid && !resp_valid));

   always_comb begin
      if (hdr.addr == OFF_ID) begin
         read_byte = word_byte(id_word, tx_cnt[1:0]);
      end else if (hdr.addr == OFF_RID) begin
         read_byte = word_byte(rid_word, tx_cnt[1:0]);
      end else if (hdr.addr == OFF_STS) begin
         read_byte = word_byte(sts_word, tx_cnt[1:0]);
      end else if (hdr.addr == OFF_DATA && data_avail) begin
         read_byte = resp_byte(resp, rd_ptr);
      end else begin
         read_byte = UNMAPPED_BYTE;
      end
   end

   always_comb begin
      next_state      = state;
      next_bit_cnt    = bit_cnt;
      next_shift_in   = shift_in;
      next_tx_shift   = tx_shift;
      next_miso       = miso_bit;
      next_hdr_cnt    = hdr_cnt;
      next_hdr        = hdr;
      next_sent_ready = sent_ready;
      next_rx_cnt     = rx_cnt;
      next_tx_cnt     = tx_cnt;
      rx_byte         = {shift_in[6:0], pins_s2.mosi};
      tx_byte         = WAIT_BYTE;
      byte_done       = 1'b0;
      load            = 1'b0;
      push            = 1'b0;
      pop_resp        = 1'b0;
      clear_cmd       = 1'b0;
      if (pins_s2.cs_n) begin
         next_state      = LK_IDLE;
         next_bit_cnt    = 3'd0;
         next_hdr_cnt    = 2'd0;
         next_sent_ready = 1'b0;
         next_rx_cnt     = 7'd0;
         next_tx_cnt     = 7'd0;
         next_miso       = 1'b0;
      end else begin
         if (state == LK_IDLE) begin
            next_state = LK_HDR;
         end
         if (clk_rise) begin
            next_shift_in = rx_byte;
            next_bit_cnt  = bit_cnt + 3'd1;
            byte_done     = (bit_cnt == 3'd7);
         end
         if (byte_done && state == LK_HDR) begin
            next_hdr_cnt = hdr_cnt + 2'd1;
            unique case (hdr_cnt)
               2'd0: begin
                  next_hdr.read   = rx_byte[HDR_READ_BIT];
                  next_hdr.len_m1 = rx_byte[5:0];
               end
               2'd1: next_hdr = hdr;
               2'd2: next_hdr.addr[15:8] = rx_byte;
               2'd3: begin
                  next_hdr.addr[7:0] = rx_byte;
                  next_state         = LK_WAIT;
               end
            endcase
         end else if (byte_done && state == LK_WAIT) begin
            if (sent_ready) begin
               next_state = LK_DATA;
            end
         end else if (byte_done && state == LK_DATA &&
                      rx_cnt <= {1'b0, hdr.len_m1}) begin
            next_rx_cnt = rx_cnt + 7'd1;
            push = !hdr.read && hdr.addr == OFF_DATA;
            clear_cmd = !hdr.read && hdr.addr == OFF_STS &&
                        rx_cnt == 7'd0 && rx_byte[STS_CMD_READY];
         end
         if (clk_fall && bit_cnt == 3'd0) begin
            load = 1'b1;
            if (state == LK_WAIT) begin
               tx_byte         = dev_ready ? READY_BYTE : WAIT_BYTE;
               next_sent_ready = dev_ready;
            end else if (state == LK_DATA &&
                         tx_cnt <= {1'b0, hdr.len_m1}) begin
               next_tx_cnt = tx_cnt + 7'd1;
               if (hdr.read) begin
                  tx_byte  = read_byte;
                  pop_resp = hdr.addr == OFF_DATA && data_avail;
               end
            end
            next_miso     = tx_byte[7];
            next_tx_shift = {tx_byte[6:0], 1'b0};
         end else if (clk_fall) begin
            next_miso     = tx_shift[7];
            next_tx_shift = {tx_shift[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         state      <= LK_IDLE;
         bit_cnt    <= 3'd0;
         shift_in   <= 8'h00;
         tx_shift   <= 8'h00;
         miso_bit   <= 1'b0;
         hdr_cnt    <= 2'd0;
         hdr        <= '0;
         sent_ready <= 1'b0;
         rx_cnt     <= 7'd0;
         tx_cnt     <= 7'd0;
      end else begin
         state      <= next_state;
         bit_cnt    <= next_bit_cnt;
         shift_in   <= next_shift_in;
         tx_shift   <= next_tx_shift;
         miso_bit   <= next_miso;
         hdr_cnt    <= next_hdr_cnt;
         hdr        <= next_hdr;
         sent_ready <= next_sent_ready;
         rx_cnt     <= next_rx_cnt;
         tx_cnt     <= next_tx_cnt;
      end
   end

   smsp_fifo #(
      .WIDTH (FIFO_WIDTH),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (rx_byte),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_data)
   );

   // The parser stalls while a response waits, which backs up the FIFO.
   assign fifo_pop = fifo_out_valid && !resp_valid;

   always_comb begin
      next_cmd_cnt    = cmd_cnt;
      next_tag        = tag;
      next_size       = size;
      next_code       = code;
      next_resp       = resp;
      next_resp_valid = resp_valid;
      next_rd_ptr     = rd_ptr;
      next_overflow   = overflow;
      next_irq_oe_n   = !data_avail;
      exec            = 1'b0;
      self_cmd        = 1'b0;
      untested        = 1'b0;
      start_test      = 1'b0;
      if (clear_cmd) begin
         next_resp_valid = 1'b0;
         next_cmd_cnt    = 16'h0000;
         next_overflow   = 1'b0;
      end
      if (pop_resp) begin
         next_rd_ptr = rd_ptr + 4'd1;
      end
      if (push && !fifo_in_ready) begin
         next_overflow = 1'b1;
      end
      if (fifo_pop) begin
         if (cmd_cnt < 16'h0002) begin
            next_tag = {tag[7:0], fifo_data};
         end else if (cmd_cnt < 16'h0006) begin
            next_size = {size[23:0], fifo_data};
         end else if (cmd_cnt <= CMD_HDR_LAST) begin
            next_code = {code[23:0], fifo_data};
         end
         next_cmd_cnt = cmd_cnt + 16'h0001;
         exec = cmd_cnt >= CMD_HDR_LAST &&
                {16'h0000, next_cmd_cnt} >= next_size;
      end
      if (exec) begin
         self_cmd = next_code == CODE_FULL_TEST ||
                    next_code == CODE_INCR_TEST;
         untested = !self_cmd && !def_done && next_code != CODE_RANDOM &&
                    next_code != CODE_HASH;
         start_test      = (self_cmd || untested) && !def_done;
         next_cmd_cnt    = 16'h0000;
         next_resp.tag   = next_tag;
         next_resp.size  = {28'h0, RESP_LEN};
         next_resp.code  = untested ? RC_TESTING : RC_SUCCESS;
         next_resp_valid = 1'b1;
         next_rd_ptr     = 4'd0;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         cmd_cnt    <= 16'h0000;
         tag        <= 16'h0000;
         size       <= 32'h0000_0000;
         code       <= 32'h0000_0000;
         resp       <= '0;
         resp_valid <= 1'b0;
         rd_ptr     <= 4'd0;
         overflow   <= 1'b0;
         irq_oe_n   <= 1'b1;
      end else begin
         cmd_cnt    <= next_cmd_cnt;
         tag        <= next_tag;
         size       <= next_size;
         code       <= next_code;
         resp       <= next_resp;
         resp_valid <= next_resp_valid;
         rd_ptr     <= next_rd_ptr;
         overflow   <= next_overflow;
         irq_oe_n   <= next_irq_oe_n;
      end
   end

   assign def_done = dt == DT_DONE;

   always_comb begin
      next_init_cnt  = init_cnt;
      next_init_done = init_done;
      next_dt        = dt;
      next_def_cnt   = def_cnt;
      next_idle_cnt  = idle_cnt;
      if (!init_done) begin
         if (init_cnt == 16'(INIT_TEST_CYC - 1)) begin
            next_init_done = 1'b1;
         end else begin
            next_init_cnt = init_cnt + 16'h0001;
         end
      end
      unique case (dt)
         DT_IDLE: begin
            next_idle_cnt = (init_done && pins_s2.cs_n) ?
                            idle_cnt + 16'h0001 : 16'h0000;
            if (start_test) begin
               next_dt = DT_CMD;
            end else if (idle_cnt == 16'(BG_IDLE_CYC - 1)) begin
               next_dt = DT_BG;
            end
         end
         DT_BG: begin
            next_def_cnt = def_cnt + 24'h00_0001;
            if (start_test) begin
               next_dt = DT_CMD;
            end else if (!pins_s2.cs_n) begin
               next_dt       = DT_IDLE;
               next_def_cnt  = 24'h00_0000;
               next_idle_cnt = 16'h0000;
            end else if (def_cnt == 24'(DEF_TEST_CYCLES - 1)) begin
               next_dt = DT_DONE;
            end
         end
         DT_CMD: begin
            next_def_cnt = def_cnt + 24'h00_0001;
            if (def_cnt == 24'(DEF_TEST_CYCLES - 1)) begin
               next_dt = DT_DONE;
            end
         end
         DT_DONE: next_dt = DT_DONE;
         default: next_dt = DT_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         init_cnt  <= 16'h0000;
         init_done <= 1'b0;
         dt        <= DT_IDLE;
         def_cnt   <= 24'h00_0000;
         idle_cnt  <= 16'h0000;
         since_rst <= 16'h0000;
      end else begin
         init_cnt  <= next_init_cnt;
         init_done <= next_init_done;
         dt        <= next_dt;
         def_cnt   <= next_def_cnt;
         idle_cnt  <= next_idle_cnt;
         since_rst <= (since_rst == 16'hffff) ? since_rst :
                      since_rst + 16'h0001;
      end
   end

   assign miso_o                     = miso_bit;
   assign interrupt_request_n_o      = 1'b0;
   assign interrupt_request_n_oe_n_o = irq_oe_n;

   a_tx_msb_first: assert property (
      load |=> miso_bit == $past(tx_byte[7]) &&
               tx_shift[7] == $past(tx_byte[6]))
      else $error("Output byte not sent msb first.");
   a_idle_unselect: assert property (
      pins_s2.cs_n |=> state == LK_IDLE && !push)
      else $error("Port active without chip select.");
   a_wait_state: assert property (
      state == LK_WAIT && load && !dev_ready |=> !sent_ready ##0
      miso_bit == 1'b0)
      else $error("Ready reported while device busy.");
   a_irq_follows: assert property (
      $rose(data_avail) |=> !interrupt_request_n_oe_n_o &&
                            !interrupt_request_n_o)
      else $error("Interrupt not pulled low on response.");
   a_irq_release: assert property (
      !data_avail ##1 !data_avail |-> interrupt_request_n_oe_n_o)
      else $error("Interrupt driven with nothing pending.");
   a_reset_clears: assert property (
      $rose(reset_n_i) |-> !init_done && !resp_valid &&
                           state == LK_IDLE && dt == DT_IDLE)
      else $error("State survived reset.");
   a_init_time: assert property (
      $rose(init_done) |-> since_rst == 16'(INIT_TEST_CYC))
      else $error("Initial test length wrong.");
   a_selftest_cmd: assert property (
      exec && self_cmd && !def_done |=> dt == DT_CMD &&
                                        resp.code == RC_SUCCESS)
      else $error("Self-test command did not start tests.");
   a_testing_code: assert property (
      exec && untested |=> resp_valid && resp.code == RC_TESTING &&
                           dt == DT_CMD)
      else $error("Untested use not answered with testing.");
   a_cmd_size: assert property (
      exec |=> cmd_cnt == 16'h0000 && resp.size == {28'h0, RESP_LEN})
      else $error("Command end or response size wrong.");
   a_bg_abort: assert property (
      dt == DT_BG && !pins_s2.cs_n && !start_test |=> dt == DT_IDLE)
      else $error("Background test not aborted.");
   a_id_read: assert property (
      load && state == LK_DATA && hdr.read && hdr.addr == OFF_ID &&
      tx_cnt == 7'd0 |=> miso_bit == VENDOR_ID[7])
      else $error("Identity register read wrong.");

   c_write_cmd: cover property (exec);
   c_wait_seen: cover property (load && state == LK_WAIT && !dev_ready);
   c_resp_read: cover property (pop_resp && rd_ptr == 4'd9);
   c_testing: cover property (exec && untested);
endmodule
`default_nettype wire

// ### verif/smsp_host_model.sv
// Host serial master model that drives the slave port in mode 3.
`timescale 1ns/1ns
`default_nettype none
module smsp_host_model (
   input  wire logic ref_clk_i,
   input  wire logic miso_i,
   output logic      spi_clk_o,
   output logic      spi_cs_n_o,
   output logic      mosi_o
);
   logic [7:0] buf_q [32];
   initial begin
      spi_clk_o = 1'b1;
      spi_cs_n_o = 1'b1;
      mosi_o = 1'b0;
   end
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      // Four cycles low and four high give a 320 ns bit, within the limit.
      for (int b = 7; b >= 0; b--) begin
         spi_clk_o = 1'b0;
         mosi_o = tx[b];
         repeat (4) @(negedge ref_clk_i);
         spi_clk_o = 1'b1;
         repeat (4) @(negedge ref_clk_i);
         rx[b] = miso_i;
      end
   endtask
   task automatic frame(input logic rd, input logic [15:0] addr,
                        input int n);
      logic [7:0] rx;
      int w;
      @(negedge ref_clk_i);
      spi_cs_n_o = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      xfer({rd, 1'b0, 6'(n - 1)}, rx);
      xfer(8'h00, rx);
      xfer(addr[15:8], rx);
      xfer(addr[7:0], rx);
      w = 0;
      rx = 8'h00;
      while (rx !== 8'h01 && w < 40) begin
         xfer(8'h00, rx);
         w++;
      end
      for (int k = 0; k < n; k++)
         xfer(buf_q[k], buf_q[k]);
      repeat (4) @(negedge ref_clk_i);
      spi_cs_n_o = 1'b1;
      // A released data line must not keep its last level.
      mosi_o = ~mosi_o;
      repeat (4) @(negedge ref_clk_i);
   endtask
endmodule
`default_nettype wire

// ### verif/test_secure_module_spi_slave.sv
// Self-checking bench for the secure module serial slave port.
`timescale 1ns/1ns
`default_nettype none
module test_secure_module_spi_slave;
   import smsp_pkg::*;
   // Identity values are arbitrary.
   localparam logic [15:0] DEV = 16'h3c5a;
   localparam logic [15:0] VEN = 16'h0777;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic spi_clk, spi_cs_n, mosi, miso, irq_n, irq_oe_n;
   wire  irq_pin = irq_oe_n ? 1'b1 : irq_n;
   int   miscompares = 0;
   int   n_tests = 0;
   always #20 ref_clk = ~ref_clk;
   smsp_spi_slave #(.DEVICE_ID(DEV), .VENDOR_ID(VEN),
      .DEF_TEST_CYCLES(40)) dut_u (
      .ref_clk_i(ref_clk), .reset_n_i(reset_n), .spi_clk_i(spi_clk),
      .spi_cs_n_i(spi_cs_n), .mosi_i(mosi), .miso_o(miso),
      .interrupt_request_n_o(irq_n),
      .interrupt_request_n_oe_n_o(irq_oe_n));
   smsp_host_model host_u (.ref_clk_i(ref_clk), .miso_i(miso),
      .spi_clk_o(spi_clk), .spi_cs_n_o(spi_cs_n), .mosi_o(mosi));
   task automatic check(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   function automatic logic [31:0] be(input int k);
      return {host_u.buf_q[k], host_u.buf_q[k+1], host_u.buf_q[k+2],
              host_u.buf_q[k+3]};
   endfunction
   task automatic rd_reg(input string what, input logic [15:0] a,
                         input logic [31:0] mask, exp);
      host_u.frame(1'b1, a, 4);
      check(what, {host_u.buf_q[3], host_u.buf_q[2], host_u.buf_q[1],
         host_u.buf_q[0]} & mask, exp);
   endtask
   task automatic send_cmd(input logic [31:0] code);
      {host_u.buf_q[0], host_u.buf_q[1]} = 16'h8001;
      {host_u.buf_q[2], host_u.buf_q[3], host_u.buf_q[4],
       host_u.buf_q[5]} = 32'h0000_000a;
      {host_u.buf_q[6], host_u.buf_q[7], host_u.buf_q[8],
       host_u.buf_q[9]} = code;
      host_u.frame(1'b0, OFF_DATA, 10);
      repeat (10) @(negedge ref_clk);
      check("irq asserted", 32'(irq_pin), 32'h0);
   endtask
   task automatic read_resp(input logic [31:0] exp);
      host_u.frame(1'b1, OFF_DATA, 10);
      check("resp tag", 32'({host_u.buf_q[0], host_u.buf_q[1]}),
         32'h8001);
      check("resp size", be(2), 32'h0000_000a);
      check("resp code", be(6), exp);
      repeat (5) @(negedge ref_clk);
      check("irq released", 32'(irq_oe_n), 32'h1);
      // Command ready drops the response so the next command is taken.
      host_u.buf_q[0] = 8'h01 << STS_CMD_READY;
      host_u.frame(1'b0, OFF_STS, 1);
      rd_reg("sts after drop", OFF_STS, 32'h14, 32'h0);
   endtask
   task automatic t_testing();
      send_cmd(32'h0000_0005);
      read_resp(RC_TESTING);
      repeat (60) @(negedge ref_clk);
      rd_reg("sts after test", OFF_STS, 32'h3, 32'h3);
      send_cmd(32'h0000_0005);
      read_resp(RC_SUCCESS);
   endtask
   task automatic t_ids();
      rd_reg("id", OFF_ID, 32'hffff_ffff, {DEV, VEN});
      for (int k = 0; k < 4; k++)
         host_u.buf_q[k] = 8'h00;
      host_u.frame(1'b0, OFF_ID, 4);
      rd_reg("id after write", OFF_ID, 32'hffff_ffff, {DEV, VEN});
      rd_reg("revision", OFF_RID, 32'hff, 32'h11);
      rd_reg("unmapped", 16'h0100, 32'hffff_ffff, 32'hffff_ffff);
      // Bytes past the command size back up the stalled FIFO until full.
      for (int k = 0; k < 20; k++)
         host_u.buf_q[k] = 8'h00;
      host_u.buf_q[5] = 8'h0a;
      host_u.buf_q[9] = CODE_RANDOM[7:0];
      host_u.frame(1'b0, OFF_DATA, 20);
      rd_reg("sts overflow", OFF_STS, 32'h14, 32'h14);
   endtask
   task automatic t_reset();
      logic [31:0] codes [4];
      codes = '{CODE_RANDOM, CODE_HASH, CODE_INCR_TEST, CODE_FULL_TEST};
      @(negedge ref_clk);
      reset_n = 1'b0;
      repeat (50) @(negedge ref_clk);
      check("irq in reset", 32'(irq_pin), 32'h1);
      reset_n = 1'b1;
      rd_reg("sts after reset", OFF_STS, 32'h13, 32'h1);
      // Idle long enough to start a background run, short enough to cut it.
      repeat (1010) @(negedge ref_clk);
      rd_reg("sts bg abort", OFF_STS, 32'h3, 32'h1);
      for (int k = 0; k < 4; k++) begin
         send_cmd(codes[k]);
         read_resp(RC_SUCCESS);
      end
      repeat (60) @(negedge ref_clk);
      rd_reg("sts deferred", OFF_STS, 32'h3, 32'h3);
   endtask
   initial begin
      repeat (10) @(negedge ref_clk);
      reset_n = 1'b1;
      t_testing();
      t_ids();
      t_reset();
      conclude();
   end
   initial begin
      repeat (60000) @(posedge ref_clk);
      miscompares++;
      conclude();
   end
endmodule
`default_nettype wire
